// >>> core/gpio_direction_output_port.sv
// Notes on behaviour
// - direction bit 0 input, 1 output
// - all configurable pins inputs after reset
// - bit n controls pin n
// - output bit 1 high, 0 low
// - small part: pin0 out, pin3 in fixed
// - lettered parts: fixed A.0/C.6 or A.4
// - shared pins change only when output
// - input and output read back separately
// - whole-port write updates pins together
// - drive-low clears output, sets direction except on fixed-input pins
// - single-pin index 0 to 7
// - port c has own direction register
// - each lettered port own output register
`timescale 1ns/100ps
module gpio_direction_output_port #(
  parameter gpio_port_pkg::variant_e VARIANT = gpio_port_pkg::VAR_LETTER_LARGE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [gpio_port_pkg::NUM_PORTS-1:0][7:0] pin_in,
  output logic [gpio_port_pkg::NUM_PORTS-1:0][7:0] pin_out,
  output logic [gpio_port_pkg::NUM_PORTS-1:0][7:0] pin_oe
);
  import gpio_port_pkg::*;

  // Which register group an address falls into, and which port
  typedef enum logic [2:0] {
    GRP_NONE   = 3'b000,
    GRP_DIR    = 3'b001,
    GRP_OUT    = 3'b010,
    GRP_IN     = 3'b011,
    GRP_CMD    = 3'b100,
    GRP_STATUS = 3'b101
  } group_e;

  function automatic group_e addr_group(logic [ADDR_W-1:0] a);
    if (a >= REG_DIR_BASE && a < REG_OUT_BASE) begin
      addr_group = GRP_DIR;
    end else if (a >= REG_OUT_BASE && a < REG_IN_BASE) begin
      addr_group = GRP_OUT;
    end else if (a >= REG_IN_BASE && a < REG_LOW_CMD) begin
      addr_group = GRP_IN;
    end else if (a == REG_LOW_CMD) begin
      addr_group = GRP_CMD;
    end else if (a == REG_STATUS) begin
      addr_group = GRP_STATUS;
    end else begin
      addr_group = GRP_NONE;
    end
  endfunction

  function automatic logic [2:0] addr_port(logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a;
    case (addr_group(a))
      GRP_DIR: off = a - REG_DIR_BASE;
      GRP_OUT: off = a - REG_OUT_BASE;
      GRP_IN: off = a - REG_IN_BASE;
      default: off = '0;
    endcase
    addr_port = off[PORT_IDX_W-1:0];
  endfunction

  localparam bit SHARED_MAIN = (VARIANT == VAR_SMALL);

  port_ctl_if ctl_if [NUM_PORTS] ();

  logic [NUM_PORTS-1:0][7:0] dir_w;
  logic [NUM_PORTS-1:0][7:0] out_w;

  group_e wr_grp;
  logic [2:0] wr_port;
  logic [2:0] cmd_port;
  logic [2:0] cmd_pin;
  logic cmd_ok;

  always_comb begin
    wr_grp = addr_group(addr);
    wr_port = addr_port(addr);
    cmd_port = wdata[CMD_PORT_LSB +: PORT_IDX_W];
    cmd_pin = wdata[CMD_PIN_LSB +: PIN_IDX_W];
    cmd_ok = port_present(VARIANT, cmd_port);
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      localparam logic [2:0] PID = 3'(gp);

      // Every port keeps its own direction and output register
      assign ctl_if[gp].dir_we = wr_en && (wr_grp == GRP_DIR) && (wr_port == PID);
      assign ctl_if[gp].out_we = wr_en && (wr_grp == GRP_OUT) && (wr_port == PID);
      assign ctl_if[gp].low_we = wr_en && (wr_grp == GRP_CMD) && cmd_ok && (cmd_port == PID);
      assign ctl_if[gp].low_idx = cmd_pin;
      assign ctl_if[gp].wdata = wdata;
      assign dir_w[gp] = ctl_if[gp].dir_q;
      assign out_w[gp] = ctl_if[gp].out_q;

      port_bank #(
        .FIX_ONE(fixed_one(VARIANT, PID)),
        .FIX_ZERO(fixed_zero(VARIANT, PID)),
        .GATED(SHARED_MAIN && (PID == PORT_MAIN)),
        .PRESENT(port_present(VARIANT, PID))
      ) u_bank (
        .clk(clk),
        .rst(rst),
        .ctl(ctl_if[gp])
      );
    end
  endgenerate

  // Pin drive straight from the bank flops; bit n is pin n
  always_comb begin
    pin_out = out_w;
    pin_oe = dir_w;
  end

  // Input sampling; pins are taken as synchronous to clk
  logic [NUM_PORTS-1:0][7:0] in_q;
  logic [NUM_PORTS-1:0][7:0] in_d;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      in_d[p] = port_present(VARIANT, 3'(p)) ? pin_in[p] : 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_q <= '0;
    end else begin
      in_q <= in_d;
    end
  end

  // Sticky reject flag for drive-low commands aimed at absent ports
  logic reject_q;
  logic reject_d;
  logic status_wr;
  logic reject_set;

  always_comb begin
    status_wr = wr_en && (wr_grp == GRP_STATUS);
    reject_set = wr_en && (wr_grp == GRP_CMD) && !cmd_ok;
    reject_d = reject_q;
    if (status_wr && wdata[STAT_REJECT_BIT]) begin
      reject_d = 1'b0;
    end
    // A new reject in the clearing cycle survives
    if (reject_set) begin
      reject_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reject_q <= 1'b0;
    end else begin
      reject_q <= reject_d;
    end
  end

  // Read path, answer one cycle after the strobe and only then
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  group_e rd_grp;
  logic [2:0] rd_port;
  logic [7:0] shared_level;

  always_comb begin
    rd_grp = addr_group(addr);
    rd_port = addr_port(addr);
    // On the shared port a driven pin reads its own output level
    shared_level = (dir_w[PORT_MAIN] & out_w[PORT_MAIN]) | (~dir_w[PORT_MAIN] & in_q[PORT_MAIN]);
    rdata_d = 8'h00;
    if (rd_en) begin
      case (rd_grp)
        GRP_DIR: rdata_d = dir_w[rd_port];
        GRP_OUT: rdata_d = out_w[rd_port];
        GRP_IN: begin
          if (SHARED_MAIN && rd_port == PORT_MAIN) begin
            rdata_d = shared_level;
          end else begin
            rdata_d = in_q[rd_port];
          end
        end
        GRP_STATUS: begin
          rdata_d[STAT_REJECT_BIT] = reject_q;
          rdata_d[STAT_VARIANT_LSB +: 2] = VARIANT;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule

// >>> core/gpio_port_pkg.sv
package gpio_port_pkg;

  typedef enum logic [1:0] {
    VAR_SMALL        = 2'b00,
    VAR_PORTC        = 2'b01,
    VAR_LETTER_MID   = 2'b10,
    VAR_LETTER_LARGE = 2'b11
  } variant_e;

  localparam int PIN_W = 8;
  localparam int NUM_PORTS = 6;
  localparam int ADDR_W = 5;
  localparam int PORT_IDX_W = 3;
  localparam int PIN_IDX_W = 3;

  // Port numbering shared by every register group
  localparam logic [2:0] PORT_MAIN = 3'h0;
  localparam logic [2:0] PORT_C = 3'h1;
  localparam logic [2:0] PORT_LA = 3'h2;
  localparam logic [2:0] PORT_LB = 3'h3;
  localparam logic [2:0] PORT_LC = 3'h4;
  localparam logic [2:0] PORT_LD = 3'h5;

  // Register map, one register per address
  localparam logic [4:0] REG_DIR_BASE = 5'h00;
  localparam logic [4:0] REG_OUT_BASE = 5'h06;
  localparam logic [4:0] REG_IN_BASE = 5'h0C;
  localparam logic [4:0] REG_LOW_CMD = 5'h12;
  localparam logic [4:0] REG_STATUS = 5'h13;

  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;

  // Drive-low command fields
  localparam int CMD_PIN_LSB = 0;
  localparam int CMD_PORT_LSB = 4;

  // Status fields
  localparam int STAT_REJECT_BIT = 0;
  localparam int STAT_VARIANT_LSB = 4;

  // Fixed pin positions
  localparam int SMALL_FIXED_OUT_PIN = 0;
  localparam int SMALL_FIXED_IN_PIN = 3;
  localparam int MID_FIXED_OUT_PIN = 0;
  localparam int MID_FIXED_IN_PIN = 6;
  localparam int LARGE_FIXED_OUT_PIN = 4;

  function automatic logic port_present(variant_e v, logic [2:0] p);
    case (v)
      VAR_SMALL: port_present = (p == PORT_MAIN);
      VAR_PORTC: port_present = (p == PORT_MAIN) || (p == PORT_C);
      default: port_present = (p >= PORT_LA) && (p <= PORT_LD);
    endcase
  endfunction

  function automatic logic [7:0] fixed_one(variant_e v, logic [2:0] p);
    fixed_one = 8'h00;
    if (v == VAR_SMALL && p == PORT_MAIN) fixed_one[SMALL_FIXED_OUT_PIN] = 1'b1;
    if (v == VAR_LETTER_MID && p == PORT_LA) fixed_one[MID_FIXED_OUT_PIN] = 1'b1;
    if (v == VAR_LETTER_LARGE && p == PORT_LA) fixed_one[LARGE_FIXED_OUT_PIN] = 1'b1;
  endfunction

  function automatic logic [7:0] fixed_zero(variant_e v, logic [2:0] p);
    fixed_zero = 8'h00;
    if (v == VAR_SMALL && p == PORT_MAIN) fixed_zero[SMALL_FIXED_IN_PIN] = 1'b1;
    if (v == VAR_LETTER_MID && p == PORT_LC) fixed_zero[MID_FIXED_IN_PIN] = 1'b1;
  endfunction

endpackage

// >>> core/port_ctl_if.sv
`timescale 1ns/100ps
interface port_ctl_if;
  logic dir_we;
  logic out_we;
  logic low_we;
  logic [2:0] low_idx;
  logic [7:0] wdata;
  logic [7:0] dir_q;
  logic [7:0] out_q;

  modport ctl (output dir_we, output out_we, output low_we, output low_idx, output wdata,
               input dir_q, input out_q);
  modport bank (input dir_we, input out_we, input low_we, input low_idx, input wdata,
                output dir_q, output out_q);
endinterface

// >>> core/port_bank.sv
`timescale 1ns/100ps
module port_bank #(
  parameter logic [7:0] FIX_ONE = 8'h00,
  parameter logic [7:0] FIX_ZERO = 8'h00,
  parameter bit GATED = 1'b0,
  parameter bit PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  port_ctl_if.bank ctl
);
  import gpio_port_pkg::*;

  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] out_q;
  logic [7:0] out_d;

  always_comb begin
    dir_d = dir_q;
    out_d = out_q;
    if (ctl.dir_we) begin
      dir_d = ctl.wdata;
    end
    if (ctl.out_we) begin
      // Shared pins only take new levels where the pin already drives
      if (GATED) begin
        out_d = (out_q & ~dir_q) | (ctl.wdata & dir_q);
      end else begin
        out_d = ctl.wdata;
      end
    end
    if (ctl.low_we) begin
      dir_d[ctl.low_idx] = 1'b1;
      out_d[ctl.low_idx] = 1'b0;
    end
    dir_d = (dir_d | FIX_ONE) & ~FIX_ZERO;
    if (!PRESENT) begin
      dir_d = 8'h00;
      out_d = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q <= PRESENT ? (DIR_RESET | FIX_ONE) : 8'h00;
      out_q <= OUT_RESET;
    end else begin
      dir_q <= dir_d;
      out_q <= out_d;
    end
  end

  assign ctl.dir_q = dir_q;
  assign ctl.out_q = out_q;

endmodule

// >>> sim/gpio_port_asserts.sv
`timescale 1ns/100ps
module gpio_port_asserts #(
  parameter gpio_port_pkg::variant_e VARIANT = gpio_port_pkg::VAR_LETTER_MID
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic [gpio_port_pkg::NUM_PORTS-1:0][7:0] pin_in,
  input wire logic [gpio_port_pkg::NUM_PORTS-1:0][7:0] pin_out,
  input wire logic [gpio_port_pkg::NUM_PORTS-1:0][7:0] pin_oe
);
  import gpio_port_pkg::*;
  logic [5:0][7:0] in_q;
  logic [4:0] lp;
  logic [2:0] li;
  assign lp = {2'b00, wdata[6:4]};
  assign li = wdata[2:0];
  // Mirror of the input sampler, so reads can be tied to pin history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_q <= '0;
    end else begin
      in_q <= pin_in;
    end
  end
  // Lettered parts only; other variants need their own masks
  function automatic logic [7:0] fx(logic [4:0] p, logic [7:0] v);
    fx = v;
    if (p == 5'h02 && VARIANT == VAR_LETTER_MID) fx[0] = 1'b1;
    if (p == 5'h02 && VARIANT == VAR_LETTER_LARGE) fx[4] = 1'b1;
    if (p == 5'h04 && VARIANT == VAR_LETTER_MID) fx[6] = 1'b0;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_dir_write: assert property (wr_en && addr inside {[2:5]} |=>
    pin_oe[$past(addr)] == fx($past(addr), $past(wdata))) else $error("direction write wrong");
  a_fixed_pins: assert property (fx(5'h02, pin_oe[2]) == pin_oe[2]
    && fx(5'h04, pin_oe[4]) == pin_oe[4]) else $error("fixed pin moved");
  a_out_write: assert property (wr_en && addr inside {[8:11]} |=>
    pin_out[$past(addr) - 6] == $past(wdata)) else $error("output write wrong");
  a_pins_hold: assert property (!wr_en |=> $stable(pin_out) && $stable(pin_oe))
    else $error("pins changed without write");
  a_low_cmd: assert property (wr_en && addr == REG_LOW_CMD && lp inside {[2:5]} |=>
    pin_oe[$past(lp)] == fx($past(lp), $past(pin_oe[lp]) | (8'h01 << $past(li)))
    && pin_out[$past(lp)] == ($past(pin_out[lp]) & ~(8'h01 << $past(li))))
    else $error("drive-low wrong");
  a_rd_idle: assert property (!rd_en |=> rdata == 8'h00) else $error("stray read data");
  a_read_dir: assert property (rd_en && addr < 6 |=> rdata == $past(pin_oe[addr]))
    else $error("direction readback wrong");
  a_read_in: assert property (rd_en && addr inside {[14:17]} |=>
    rdata == $past(in_q[addr - 12])) else $error("input read wrong");
  c_dir: cover property (wr_en && addr inside {[2:5]});
  c_low: cover property (wr_en && addr == REG_LOW_CMD);
  c_in: cover property (rd_en && addr inside {[14:17]});
endmodule

// >>> sim/pin_model.sv
`timescale 1ns/100ps
module pin_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0][7:0] pin_out,
  input wire logic [5:0][7:0] pin_oe,
  output logic [5:0][7:0] pin_in
);
  logic [47:0] pat_q;
  logic [47:0] pat_d;
  // Undriven pins wander so a stale level never passes as valid
  always_comb pat_d = {pat_q[46:0], ~pat_q[47] ^ pat_q[20]};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pat_q <= 48'h5a5a_0f0f_3c3c;
    end else begin
      pat_q <= pat_d;
    end
  end
  assign pin_in = (pin_out & pin_oe) | (pat_q & ~pin_oe);
endmodule

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
  import gpio_port_pkg::*;
  localparam variant_e VAR = VAR_LETTER_MID;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic [5:0][7:0] pin_in;
  logic [5:0][7:0] pin_out;
  logic [5:0][7:0] pin_oe;
  logic [5:0][7:0] dq;
  logic [5:0][7:0] oq;
  logic [5:0][7:0] pin_q;
  logic [5:0][7:0] pin_qq;
  logic [31:0] seed = 32'hadb9_8a08;
  logic [7:0] v;
  int n_fail = 0;
  int checked = 0;
  int p;
  gpio_direction_output_port #(.VARIANT(VAR)) DUT (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  pin_model far (.clk(clk), .rst(rst), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  // Pin history two edges deep, the age of what an input read returns
  always @(posedge clk) begin
    pin_q <= pin_in;
    pin_qq <= pin_q;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] fx(int q, logic [7:0] d);
    fx = d;
    if (q == 2) fx[0] = 1'b1;
    if (q == 4) fx[6] = 1'b0;
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic sweep();
    for (int q = 0; q < 6; q++) begin
      chk("pin_oe", pin_oe[q], dq[q]);
      chk("pin_out", pin_out[q], oq[q]);
      rd(5'(q), v);
      chk("dir_read", v, dq[q]);
      rd(5'(q + 6), v);
      chk("out_read", v, oq[q]);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    dq = '0;
    oq = '0;
    dq[2] = fx(2, 8'h00);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    sweep();
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      p = 2 + seed[1:0];
      dq[p] = fx(p, seed[15:8]);
      oq[p] = seed[23:16];
      wr(5'(p), seed[15:8]);
      wr(5'(p + 6), seed[23:16]);
      rd(5'(p + 12), v);
      chk("in_read", v & dq[p], oq[p] & dq[p]);
      chk("in_pins", v, pin_qq[p]);
    end
    sweep();
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      p = 2 + seed[1:0];
      wr(REG_LOW_CMD, {1'b0, 3'(p), 1'b0, 3'(i)});
      dq[p] = fx(p, dq[p] | (8'h01 << i));
      oq[p][i] = 1'b0;
    end
    sweep();
    wr(5'h1f, 8'hff);
    rd(5'h1f, v);
    chk("unmapped", v, 8'h00);
    wr(REG_LOW_CMD, 8'h03);
    rd(REG_STATUS, v);
    chk("status", v, {2'b00, VAR, 4'h1});
    wr(REG_STATUS, 8'h01);
    rd(REG_STATUS, v);
    chk("status_clr", v, {2'b00, VAR, 4'h0});
    // Absent ports must swallow writes and stay undriven
    wr(5'h00, 8'hff);
    wr(5'h06, 8'hff);
    sweep();
    stop_test();
  end
endmodule
bind gpio_direction_output_port gpio_port_asserts #(.VARIANT(VARIANT)) chk_i (.clk(clk),
  .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
